// ### ogtb_trim_bank.sv
// Offset and fine gain trim register bank with input-dependent trim selection.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module ogtb_trim_bank
  import ogtb_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire ogtb_pkg::ogtb_req_s   busReq,
  output logic [ogtb_pkg::DATA_W-1:0] rdData,
  input  wire ogtb_pkg::ogtb_fuse_s  fuseData,
  input  wire logic                  fuseValid,
  input  wire logic                  core2InputB,
  input  wire logic                  core3InputD,
  output ogtb_pkg::ogtb_trim_s       trimOut,
  output logic                       fuseLoaded
);
  import ogtb_pkg::*;

  logic [DATA_W-1:0] ofsReg  [NUM_OFS];
  logic [DATA_W-1:0] gainReg [NUM_GAIN];
  logic              loadedReg;
  logic              fuseLoad;
  logic [NUM_OFS-1:0]  ofsHit;
  logic [NUM_GAIN-1:0] gainHit;
  logic [ADDR_W-1:0]   ofsAddr  [NUM_OFS];
  logic [ADDR_W-1:0]   gainAddr [NUM_GAIN];

  assign ofsAddr[OFS_2A]    = OFFSET_TRIM_CORE2_INPUT_A_ADDR;
  assign ofsAddr[OFS_2B]    = OFFSET_TRIM_CORE2_INPUT_B_ADDR;
  assign ofsAddr[OFS_3C]    = OFFSET_TRIM_CORE3_INPUT_C_ADDR;
  assign ofsAddr[OFS_3D]    = OFFSET_TRIM_CORE3_INPUT_D_ADDR;
  assign ofsAddr[OFS_4]     = OFFSET_TRIM_CORE4_ADDR;
  assign ofsAddr[OFS_5]     = OFFSET_TRIM_CORE5_ADDR;
  assign gainAddr[GAIN_0]   = GAIN_TRIM_CORE_ZERO_ADDR;
  assign gainAddr[GAIN_1]   = GAIN_TRIM_CORE_ONE_ADDR;
  assign gainAddr[GAIN_2A]  = GAIN_TRIM_CORE_TWO_INPUT_A_ADDR;

  // Fuse contents are taken once, on the first cycle the fuse data is valid.
  assign fuseLoad = fuseValid && !loadedReg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loadedReg <= 1'b0;
    end else if (fuseLoad) begin
      loadedReg <= 1'b1;
    end
  end

  assign fuseLoaded = loadedReg;

  genvar i;
  generate
    for (i = 0; i < NUM_OFS; i++) begin : g_ofs
      assign ofsHit[i] = (busReq.addr == ofsAddr[i]);
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          ofsReg[i] <= TRIM_RESET;
        end else if (fuseLoad) begin
          ofsReg[i] <= {{(DATA_W-OFS_W){1'b0}}, fuseData.ofs[i*OFS_W +: OFS_W]};
        end else if (busReq.wr && ofsHit[i]) begin
          ofsReg[i] <= busReq.wdata;
        end
      end
    end
    for (i = 0; i < NUM_GAIN; i++) begin : g_gain
      assign gainHit[i] = (busReq.addr == gainAddr[i]);
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          gainReg[i] <= TRIM_RESET;
        end else if (fuseLoad) begin
          gainReg[i] <= {{(DATA_W-GAIN_W){1'b0}}, fuseData.gain[i*GAIN_W +: GAIN_W]};
        end else if (busReq.wr && gainHit[i]) begin
          gainReg[i] <= {{(DATA_W-GAIN_REG_W){1'b0}}, busReq.wdata[GAIN_REG_W-1:0]};
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= READ_ZERO;
    end else if (busReq.rd) begin
      rdData <= READ_ZERO;
      for (int k = 0; k < NUM_OFS; k++) begin
        if (ofsHit[k]) begin
          rdData <= ofsReg[k];
        end
      end
      for (int k = 0; k < NUM_GAIN; k++) begin
        if (gainHit[k]) begin
          rdData <= gainReg[k];
        end
      end
    end else begin
      rdData <= READ_ZERO;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trimOut <= '0;
    end else begin
      trimOut.core2Ofs  <= core2InputB ? ofsReg[OFS_2B][OFS_W-1:0] : ofsReg[OFS_2A][OFS_W-1:0];
      trimOut.core3Ofs  <= core3InputD ? ofsReg[OFS_3D][OFS_W-1:0] : ofsReg[OFS_3C][OFS_W-1:0];
      trimOut.core4Ofs  <= ofsReg[OFS_4][OFS_W-1:0];
      trimOut.core5Ofs  <= ofsReg[OFS_5][OFS_W-1:0];
      trimOut.core0Gain <= gainReg[GAIN_0][GAIN_W-1:0];
      trimOut.core1Gain <= gainReg[GAIN_1][GAIN_W-1:0];
      trimOut.core2Gain <= gainReg[GAIN_2A][GAIN_W-1:0];
    end
  end

endmodule : ogtb_trim_bank

// ### ogtb_pkg.sv
// Package with register map, field layout and carrier types of the offset and gain trim bank.
package ogtb_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int OFS_W  = 12;
  localparam int GAIN_W = 5;
  // Width of a gain register as stored; upper bits of the data word are dropped.
  localparam int GAIN_REG_W = 8;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] OFFSET_TRIM_CORE2_INPUT_A_ADDR = 12'h334;
  localparam logic [ADDR_W-1:0] OFFSET_TRIM_CORE2_INPUT_B_ADDR = 12'h336;
  localparam logic [ADDR_W-1:0] OFFSET_TRIM_CORE3_INPUT_C_ADDR = 12'h338;
  localparam logic [ADDR_W-1:0] OFFSET_TRIM_CORE3_INPUT_D_ADDR = 12'h33A;
  localparam logic [ADDR_W-1:0] OFFSET_TRIM_CORE4_ADDR         = 12'h33C;
  localparam logic [ADDR_W-1:0] OFFSET_TRIM_CORE5_ADDR         = 12'h33E;
  localparam logic [ADDR_W-1:0] GAIN_TRIM_CORE_ZERO_ADDR       = 12'h360;
  localparam logic [ADDR_W-1:0] GAIN_TRIM_CORE_ONE_ADDR        = 12'h361;
  localparam logic [ADDR_W-1:0] GAIN_TRIM_CORE_TWO_INPUT_A_ADDR = 12'h362;

  // Reset value of every register before the fuse load.
  localparam logic [DATA_W-1:0] TRIM_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] READ_ZERO  = 16'h0000;

  // Number of offset and gain registers held.
  localparam int NUM_OFS  = 6;
  localparam int NUM_GAIN = 3;

  // Offset register indices.
  localparam int OFS_2A = 0;
  localparam int OFS_2B = 1;
  localparam int OFS_3C = 2;
  localparam int OFS_3D = 3;
  localparam int OFS_4  = 4;
  localparam int OFS_5  = 5;
  // Gain register indices.
  localparam int GAIN_0  = 0;
  localparam int GAIN_1  = 1;
  localparam int GAIN_2A = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ogtb_req_s;

  typedef struct packed {
    logic [NUM_OFS*OFS_W-1:0]   ofs;
    logic [NUM_GAIN*GAIN_W-1:0] gain;
  } ogtb_fuse_s;

  typedef struct packed {
    logic [OFS_W-1:0]  core2Ofs;
    logic [OFS_W-1:0]  core3Ofs;
    logic [OFS_W-1:0]  core4Ofs;
    logic [OFS_W-1:0]  core5Ofs;
    logic [GAIN_W-1:0] core0Gain;
    logic [GAIN_W-1:0] core1Gain;
    logic [GAIN_W-1:0] core2Gain;
  } ogtb_trim_s;

endpackage : ogtb_pkg

// ### ogtb_trim_bank_chk.sv
// Port checker of the trim bank.
`timescale 1ns/1ps
module ogtb_trim_bank_chk
  import ogtb_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire ogtb_req_s   busReq,
  input wire logic [15:0] rdData,
  input wire ogtb_fuse_s  fuseData,
  input wire logic        core2InputB,
  input wire logic        core3InputD,
  input wire ogtb_trim_s  trimOut,
  input wire logic        fuseLoaded
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic        wrOk = fuseLoaded && busReq.wr;
  wire logic [11:0] a    = busReq.addr;
  wire logic [11:0] w    = busReq.wdata[11:0];
  wire ogtb_trim_s  t    = trimOut;
  AST_RD_IDLE: assert property (!$past(busReq.rd) |-> rdData == '0)
    else $error("read data not idle");
  AST_CORE4: assert property (wrOk && a == 12'h33C |-> ##2 t.core4Ofs == $past(w, 2))
    else $error("core 4 offset wrong");
  AST_CORE5: assert property (wrOk && a == 12'h33E |-> ##2 t.core5Ofs == $past(w, 2))
    else $error("core 5 offset wrong");
  AST_GAIN_TRIM_CORE_ZERO: assert property (wrOk && a == 12'h360 |-> ##2 t.core0Gain == $past(w[4:0], 2))
    else $error("core 0 gain wrong");
  AST_GAIN_TRIM_CORE_ONE: assert property (wrOk && a == 12'h361 |-> ##2 t.core1Gain == $past(w[4:0], 2))
    else $error("core 1 gain wrong");
  AST_CORE2A: assert property (wrOk && a == 12'h334 && !core2InputB ##1 !core2InputB [*2]
    |-> t.core2Ofs == $past(w, 2)) else $error("core 2 input A offset wrong");
  AST_CORE2B: assert property (wrOk && a == 12'h336 && core2InputB ##1 core2InputB [*2]
    |-> t.core2Ofs == $past(w, 2)) else $error("core 2 input B offset wrong");
  AST_FUSE: assert property ($rose(fuseLoaded) |=> t.core5Ofs == fuseData.ofs[71:60])
    else $error("fuse default not applied");
  AST_CORE3C: assert property (wrOk && a == 12'h338 && !core3InputD ##1 !core3InputD [*2]
    |-> t.core3Ofs == $past(w, 2)) else $error("core 3 input C offset wrong");
  AST_CORE3D: assert property (wrOk && a == 12'h33A && core3InputD ##1 core3InputD [*2]
    |-> t.core3Ofs == $past(w, 2)) else $error("core 3 input D offset wrong");
  AST_GAIN_TRIM_CORE_TWO_INPUT_A: assert property (wrOk && a == 12'h362 && !core2InputB ##1 !core2InputB [*2]
    |-> t.core2Gain == $past(w[4:0], 2)) else $error("core 2 input A gain wrong");
endmodule : ogtb_trim_bank_chk

bind ogtb_trim_bank ogtb_trim_bank_chk chk_u (.clk, .nrst, .busReq, .rdData, .fuseData,
  .core2InputB, .core3InputD, .trimOut, .fuseLoaded);

// ### ogtb_trim_bank_tb.sv
// Self-checking bench of the trim bank.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module ogtb_trim_bank_tb;
  import ogtb_pkg::*;
  logic        clk = 0, nrst = 0, fuseValid = 0, core2InputB = 0, core3InputD = 0;
  ogtb_req_s   busReq = '0;
  ogtb_fuse_s  fuseData = '{72'h5554443332221110F0, 15'h4E51};
  logic [15:0] rdData;
  ogtb_trim_s  trimOut;
  logic        fuseLoaded;
  int          miscompares = 0, comparisons = 0;
  logic [11:0] ad [9] = '{12'h334, 12'h336, 12'h338, 12'h33A, 12'h33C, 12'h33E, 12'h360,
                          12'h361, 12'h362};
  logic [15:0] dt [9] = '{16'h00A1, 16'h00B2, 16'h00C3, 16'h0FFF, 16'h0004, 16'h0805,
                          16'h001F, 16'h0001, 16'h000A};
  always #4 clk = ~clk;
  ogtb_trim_bank dut_u (.clk, .nrst, .busReq, .rdData, .fuseData, .fuseValid, .core2InputB,
    .core3InputD, .trimOut, .fuseLoaded);
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk) busReq <= '{a, d, 1'b1, 1'b0};
  endtask : wr
  task automatic idle(input int n);
    repeat (n) @(posedge clk) busReq <= '0;
  endtask : idle
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk) busReq <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk) busReq <= '0;
    #1 `CHK("read data", e, rdData)
  endtask : rd
  task automatic t_fuse();
    rd(12'h33C, 16'h0000);
    `CHK("fuse loaded", 1'b0, fuseLoaded)
    @(posedge clk) fuseValid <= 1'b1;
    idle(2);
    #1 `CHK("core 3 offset", 12'h222, trimOut.core3Ofs)
    `CHK("fuse loaded", 1'b1, fuseLoaded)
    rd(12'h336, 16'h0111);
  endtask : t_fuse
  task automatic t_rw();
    for (int i = 0; i < 9; i++) wr(ad[i], dt[i]);
    for (int i = 0; i < 9; i++) rd(ad[i], dt[i]);
    rd(12'h340, 16'h0000);
    `CHK("core 4 offset", 12'h004, trimOut.core4Ofs)
    `CHK("core 5 offset", 12'h805, trimOut.core5Ofs)
    `CHK("core 0 gain", 5'h1F, trimOut.core0Gain)
    `CHK("core 1 gain", 5'h01, trimOut.core1Gain)
  endtask : t_rw
  task automatic t_sel();
    `CHK("core 2 gain", 5'h0A, trimOut.core2Gain)
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) {core2InputB, core3InputD} <= {2{s[0]}};
      idle(2);
      #1 `CHK("core 3 offset", s ? 12'hFFF : 12'h0C3, trimOut.core3Ofs)
      `CHK("core 2 offset", s ? 12'h0B2 : 12'h0A1, trimOut.core2Ofs)
    end
    wr(12'h336, 16'h00B2);
    wr(12'h33A, 16'h0FFF);
    idle(3);
  endtask : t_sel
  task automatic finish_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_fuse();
    t_rw();
    t_sel();
    finish_test();
  end
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end
endmodule : ogtb_trim_bank_tb
